// *** rtl/nxb_device.sv ***
`timescale 1ns/10ps
module nxb_device
  import nxb_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RSTN,
  input  wire logic       BUS_STROBE_N,
  input  wire logic [2:0] CYCLE_SELECT_LINES,
  input  wire logic [7:0] NIBBLE_DATA_IN,
  output logic      [3:0] NIBBLE_DATA_OUT,
  output logic      [3:0] NIBBLE_DATA_OE,
  input  wire logic [5:0] OUT_JUMPER,
  input  wire logic [6:0] IN_JUMPER,
  input  wire logic [3:0] INPUT_BITS,
  output logic      [7:0] DIGITAL_OUT,
  output logic            OUT_SELECTED,
  output logic            IN_SELECTED
);

  // classify a 12-bit address by its first two nibbles
  function automatic nxb_region_t region_of(input logic [3:0] n1, input logic [3:0] n2);
    nxb_region_t r;
    r = RGN_NONE;
    if (n1[3:1] == NXB_NIB_HI_MAKER) begin
      r = RGN_MAKER;
    end else if (n1[3:1] == NXB_NIB_HI_ZERO) begin
      if (n2[3:1] == NXB_N2_DIG_OUT) begin
        r = RGN_DIG_OUT;
      end else if (n2[3:1] == NXB_N2_ANA_OUT) begin
        r = RGN_ANA_OUT;
      end else if (n2[3:2] == NXB_N2_DIG_IN) begin
        r = RGN_DIG_IN;
      end else if (n2[3:2] == NXB_N2_ANA_IN) begin
        r = RGN_ANA_IN;
      end else if (n2[3:2] == NXB_N2_USER) begin
        r = RGN_USER;
      end
    end
    return r;
  endfunction : region_of

  // prefix match of the output board: lvl 0..2 checks nibbles up to lvl
  function automatic logic out_match(input int lvl, input logic [3:0] n1, input logic [3:0] n2,
                                     input logic [3:0] n3, input logic [5:0] jp);
    logic ok;
    ok = (n1[3:1] == NXB_NIB_HI_ZERO) && (n1[0] == jp[5]);
    if (lvl >= 1) begin
      ok = ok && (region_of(n1, n2) == RGN_DIG_OUT) && (n2[0] == jp[4]);
    end
    if (lvl >= 2) begin
      ok = ok && (n3 == jp[3:0]);
    end
    return ok;
  endfunction : out_match

  // prefix match of the input board
  function automatic logic in_match(input int lvl, input logic [3:0] n1, input logic [3:0] n2,
                                    input logic [3:0] n3, input logic [6:0] jp);
    logic ok;
    ok = (n1[3:1] == NXB_NIB_HI_ZERO) && (n1[0] == jp[6]);
    if (lvl >= 1) begin
      ok = ok && (region_of(n1, n2) == RGN_DIG_IN) && (n2[1:0] == jp[5:4]);
    end
    if (lvl >= 2) begin
      ok = ok && (n3 == jp[3:0]);
    end
    return ok;
  endfunction : in_match

  // two-flop synchronisers for every pin input except the clock and RSTN
  logic       strobe_meta_reg;
  logic       strobe_sync_reg;
  logic [2:0] sel_meta_reg;
  logic [2:0] sel_sync_reg;
  logic [7:0] data_meta_reg;
  logic [7:0] data_sync_reg;
  logic [5:0] ojp_meta_reg;
  logic [5:0] ojp_sync_reg;
  logic [6:0] ijp_meta_reg;
  logic [6:0] ijp_sync_reg;
  logic [3:0] inb_meta_reg;
  logic [3:0] inb_sync_reg;

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      strobe_meta_reg <= 1'b1;
      strobe_sync_reg <= 1'b1;
      sel_meta_reg    <= 3'h0;
      sel_sync_reg    <= 3'h0;
      data_meta_reg   <= 8'h00;
      data_sync_reg   <= 8'h00;
    end else begin
      strobe_meta_reg <= BUS_STROBE_N;
      strobe_sync_reg <= strobe_meta_reg;
      sel_meta_reg    <= CYCLE_SELECT_LINES;
      sel_sync_reg    <= sel_meta_reg;
      data_meta_reg   <= NIBBLE_DATA_IN;
      data_sync_reg   <= data_meta_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ojp_meta_reg <= 6'h00;
      ojp_sync_reg <= 6'h00;
      ijp_meta_reg <= 7'h00;
      ijp_sync_reg <= 7'h00;
      inb_meta_reg <= 4'h0;
      inb_sync_reg <= 4'h0;
    end else begin
      ojp_meta_reg <= OUT_JUMPER;
      ojp_sync_reg <= ojp_meta_reg;
      ijp_meta_reg <= IN_JUMPER;
      ijp_sync_reg <= ijp_meta_reg;
      inb_meta_reg <= INPUT_BITS;
      inb_sync_reg <= inb_meta_reg;
    end
  end

  // cycle capture while the strobe is low, commit when it rises
  logic       strobe_low;
  logic       strobe_low_prev_reg;
  nxb_cycle_t cap_cyc_reg;
  logic [7:0] cap_data_reg;
  logic       commit;
  nxb_cycle_t live_cyc;

  assign strobe_low = ~strobe_sync_reg;
  assign live_cyc   = nxb_cycle_t'(sel_sync_reg);
  assign commit     = strobe_low_prev_reg && !strobe_low;

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      strobe_low_prev_reg <= 1'b0;
    end else begin
      strobe_low_prev_reg <= strobe_low;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      cap_cyc_reg  <= CYC_READ_FIRST;
      cap_data_reg <= 8'h00;
    end else if (strobe_low) begin
      cap_cyc_reg  <= live_cyc;
      cap_data_reg <= data_sync_reg;
    end
  end

  logic bus_reset_ev;
  assign bus_reset_ev = commit && (cap_cyc_reg == CYC_BUS_RESET);

  // three address stages
  logic [7:0] stage_byte [NXB_STAGES];
  logic       stage_valid [NXB_STAGES];
  logic [3:0] nib [NXB_STAGES];

  genvar k;
  generate
    for (k = 0; k < NXB_STAGES; k++) begin : g_stage
      logic       load_k;
      logic       clear_k;
      logic       prior_ok;
      logic       hit_k;
      logic [3:0] p1;
      logic [3:0] p2;
      logic [3:0] p3;

      assign nib[k]  = stage_byte[k][3:0];
      assign load_k  = commit && (cap_cyc_reg == nxb_cycle_t'(CYC_ADDR_FIRST + k));
      // a fresh earlier nibble drops every later one; a lone third cycle keeps the rest
      assign clear_k = bus_reset_ev || (commit && (cap_cyc_reg >= CYC_ADDR_FIRST)
                       && (cap_cyc_reg < nxb_cycle_t'(CYC_ADDR_FIRST + k)));
      assign prior_ok = (k == 0) ? 1'b1 : stage_valid[(k == 0) ? 0 : k - 1];
      assign p1 = (k == 0) ? cap_data_reg[3:0] : nib[0];
      assign p2 = (k == 1) ? cap_data_reg[3:0] : nib[1];
      assign p3 = cap_data_reg[3:0];
      assign hit_k = prior_ok && (out_match(k, p1, p2, p3, ojp_sync_reg)
                     || in_match(k, p1, p2, p3, ijp_sync_reg));

      nxb_addr_stage u_stage (
        .clk     (SYS_CLK),
        .rst_n   (RSTN),
        .clear   (clear_k),
        .load    (load_k),
        .hit     (hit_k),
        .din     (cap_data_reg),
        .byte_q  (stage_byte[k]),
        .valid_q (stage_valid[k])
      );
    end
  endgenerate

  // selection holds until the address changes
  logic all_valid;
  logic sel_out;
  logic sel_in;

  assign all_valid = stage_valid[0] && stage_valid[1] && stage_valid[2];
  assign sel_out   = all_valid && out_match(2, nib[0], nib[1], nib[2], ojp_sync_reg);
  assign sel_in    = all_valid && in_match(2, nib[0], nib[1], nib[2], ijp_sync_reg);

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      OUT_SELECTED <= 1'b0;
      IN_SELECTED  <= 1'b0;
    end else begin
      OUT_SELECTED <= sel_out;
      IN_SELECTED  <= sel_in;
    end
  end

  // output control register write
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN || bus_reset_ev) begin
      DIGITAL_OUT <= NXB_OUT_RESET;
    end else if (commit && (cap_cyc_reg == CYC_WRITE) && sel_out) begin
      // upper data bits are ignored
      DIGITAL_OUT[cap_data_reg[NXB_SEL_MSB:NXB_SEL_LSB]] <= cap_data_reg[NXB_VAL_BIT];
    end
  end

  // read drive, only on the low nibble and only while selected
  logic [3:0] data_next;
  logic [3:0] oe_next;

  always_comb begin
    data_next = 4'h0;
    oe_next   = 4'h0;
    if (strobe_low) begin
      if (sel_out && (live_cyc <= CYC_READ_THIRD)) begin
        data_next = NXB_PRESENT_DATA;
        oe_next   = NXB_OE_PRESENT;
      end else if (sel_in && (live_cyc == CYC_READ_FIRST)) begin
        data_next = inb_sync_reg;
        oe_next   = NXB_OE_NIBBLE;
      end else if (sel_in && (live_cyc == CYC_READ_SECOND)) begin
        data_next = NXB_PRESENT_DATA;
        oe_next   = NXB_OE_PRESENT;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      NIBBLE_DATA_OUT <= 4'h0;
      NIBBLE_DATA_OE  <= 4'h0;
    end else begin
      NIBBLE_DATA_OUT <= data_next;
      NIBBLE_DATA_OE  <= oe_next;
    end
  end

endmodule : nxb_device

// *** rtl/nxb_pkg.sv ***
package nxb_pkg;

  typedef enum logic [2:0] {
    CYC_READ_FIRST   = 3'b000,
    CYC_READ_SECOND  = 3'b001,
    CYC_READ_THIRD   = 3'b010,
    CYC_BUS_RESET    = 3'b011,
    CYC_ADDR_FIRST   = 3'b100,
    CYC_ADDR_SECOND  = 3'b101,
    CYC_ADDR_THIRD   = 3'b110,
    CYC_WRITE        = 3'b111
  } nxb_cycle_t;

  typedef enum logic [2:0] {
    RGN_NONE     = 3'b000,
    RGN_DIG_OUT  = 3'b001,
    RGN_ANA_OUT  = 3'b010,
    RGN_DIG_IN   = 3'b011,
    RGN_ANA_IN   = 3'b100,
    RGN_USER     = 3'b101,
    RGN_MAKER    = 3'b110
  } nxb_region_t;

  localparam int         NXB_STAGES        = 3;
  localparam logic [2:0] NXB_NIB_HI_ZERO   = 3'h0;
  localparam logic [2:0] NXB_NIB_HI_MAKER  = 3'h1;
  localparam logic [1:0] NXB_N2_DIG_IN     = 2'h1;
  localparam logic [1:0] NXB_N2_ANA_IN     = 2'h2;
  localparam logic [1:0] NXB_N2_USER       = 2'h3;
  localparam logic [2:0] NXB_N2_DIG_OUT    = 3'h0;
  localparam logic [2:0] NXB_N2_ANA_OUT    = 3'h1;
  localparam int         NXB_VAL_BIT       = 0;
  localparam int         NXB_SEL_LSB       = 1;
  localparam int         NXB_SEL_MSB       = 3;
  localparam int         NXB_PRESENT_BIT   = 0;
  localparam logic [7:0] NXB_OUT_RESET     = 8'h00;
  localparam logic [3:0] NXB_OE_NIBBLE     = 4'hF;
  localparam logic [3:0] NXB_OE_PRESENT    = 4'h1;
  localparam logic [3:0] NXB_PRESENT_DATA  = 4'h0;

endpackage : nxb_pkg

// *** rtl/nxb_addr_stage.sv ***
`timescale 1ns/10ps
module nxb_addr_stage
  import nxb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       load,
  input  wire logic       hit,
  input  wire logic [7:0] din,
  output logic      [7:0] byte_q,
  output logic            valid_q
);

  // whole byte kept so 8-bit addressing is latched as well
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byte_q <= 8'h00;
    end else if (load && hit) begin
      byte_q <= din;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      valid_q <= 1'b0;
    end else if (load) begin
      valid_q <= hit;
    end
  end

endmodule : nxb_addr_stage

// *** verif/nxb_device_props.sv ***
`timescale 1ns/10ps
module nxb_device_props
  import nxb_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RSTN,
  input wire logic       BUS_STROBE_N,
  input wire logic [3:0] NIBBLE_DATA_OUT,
  input wire logic [3:0] NIBBLE_DATA_OE,
  input wire logic [7:0] DIGITAL_OUT,
  input wire logic       OUT_SELECTED,
  input wire logic       IN_SELECTED
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  chk_rst_clear: assert property (
    $rose(RSTN) |-> DIGITAL_OUT == 8'h00 && !OUT_SELECTED && !IN_SELECTED)
    else $error("outputs not clear after reset");
  chk_oe_release: assert property (
    BUS_STROBE_N [*6] |-> NIBBLE_DATA_OE == 4'h0) else $error("data lines held");
  chk_present_low: assert property (
    NIBBLE_DATA_OE == 4'h1 |-> !NIBBLE_DATA_OUT[0]) else $error("presence bit high");
  chk_oe_selected: assert property (
    NIBBLE_DATA_OE != 4'h0 |-> OUT_SELECTED || IN_SELECTED) else $error("unselected drive");
  chk_in_nibble: assert property (
    NIBBLE_DATA_OE == 4'hF |-> IN_SELECTED) else $error("nibble driven by wrong board");
  chk_sel_excl: assert property (
    !(OUT_SELECTED && IN_SELECTED)) else $error("both boards selected");
  chk_one_output: assert property (
    $changed(DIGITAL_OUT) && DIGITAL_OUT != 8'h00
    |-> $countones(DIGITAL_OUT ^ $past(DIGITAL_OUT)) == 1) else $error("many outputs moved");
  chk_out_needs_sel: assert property (
    $changed(DIGITAL_OUT) && DIGITAL_OUT != 8'h00 |-> $past(OUT_SELECTED))
    else $error("write without selection");
  chk_oe_rise: assert property (
    $rose(|NIBBLE_DATA_OE) |-> !BUS_STROBE_N && !$past(BUS_STROBE_N, 2))
    else $error("drive outside strobe");
endmodule : nxb_device_props

bind nxb_device nxb_device_props chk_u (
  .SYS_CLK(SYS_CLK), .RSTN(RSTN), .BUS_STROBE_N(BUS_STROBE_N),
  .NIBBLE_DATA_OUT(NIBBLE_DATA_OUT), .NIBBLE_DATA_OE(NIBBLE_DATA_OE),
  .DIGITAL_OUT(DIGITAL_OUT), .OUT_SELECTED(OUT_SELECTED), .IN_SELECTED(IN_SELECTED)
);

// *** verif/nxb_host.sv ***
`timescale 1ns/10ps
module nxb_host (
  input  wire logic       clk,
  input  wire logic [7:0] bus_w,
  output logic            strobe_n,
  output logic      [2:0] sel,
  output logic      [7:0] hd,
  output logic            hen
);
  // one address cycle with this byte selects the expansion register
  localparam logic [7:0] EXP_REG_SELECT = 8'h0B;
  initial begin
    strobe_n = 1'b1;
    sel = 3'h0;
    hd = 8'h00;
    hen = 1'b0;
  end
  task automatic cyc(input logic [2:0] s, input logic [7:0] d, output logic [7:0] r);
    logic [7:0] port_img;
    // port image: strobe in line 0, data in lines 1..4, select in lines 5..7
    port_img = {s, d[3:0], 1'b0};
    @(posedge clk);
    strobe_n <= port_img[0];
    sel <= port_img[7:5];
    hd <= {d[7:4], port_img[4:1]};
    hen <= s[2];
    repeat (5) @(posedge clk);
    // all eight lines handed back; callers keep only the bits they use
    r = bus_w;
    strobe_n <= 1'b1;
    // select lines wander while idle
    sel <= ~s;
    hen <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : cyc
  task automatic addr3(input logic [11:0] a);
    logic [7:0] r;
    cyc(3'h4, {4'h0, a[11:8]}, r);
    cyc(3'h5, {4'h0, a[7:4]}, r);
    cyc(3'h6, {4'h0, a[3:0]}, r);
  endtask : addr3
  task automatic addr16(input logic [15:0] a);
    logic [7:0] r;
    cyc(3'h4, EXP_REG_SELECT, r);
    cyc(3'h7, {4'h0, a[15:12]}, r);
    addr3(a[11:0]);
  endtask : addr16
  task automatic bus_reset;
    logic [7:0] r;
    cyc(3'h3, 8'h00, r);
    repeat (20) @(posedge clk);
  endtask : bus_reset
endmodule : nxb_host

// *** verif/nxb_device_bench.sv ***
`timescale 1ns/10ps
module nxb_device_bench;
  import nxb_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        stb_n;
  logic [2:0]  sel;
  logic [7:0]  hd;
  logic        hen;
  logic [3:0]  dout;
  logic [3:0]  oe;
  logic [5:0]  ojp;
  logic [6:0]  ijp;
  logic [3:0]  inb;
  logic [7:0]  dig;
  logic        osel;
  logic        isel;
  logic [7:0]  rd;
  logic [11:0] lat;
  logic [31:0] rs;
  int          exp_out;
  int          fail_count;
  int          checks;
  int          cyc_n;
  // undriven lines are pulled high
  wire  [7:0]  bus_w = ({4'h0, oe} & {4'h0, dout}) | ({4'hF, ~oe} & (hen ? hd : 8'hFF));

  always #5 clk = ~clk;

  nxb_device dut_u (
    .SYS_CLK(clk), .RSTN(rst_n), .BUS_STROBE_N(stb_n), .CYCLE_SELECT_LINES(sel),
    .NIBBLE_DATA_IN(bus_w), .NIBBLE_DATA_OUT(dout), .NIBBLE_DATA_OE(oe),
    .OUT_JUMPER(ojp), .IN_JUMPER(ijp), .INPUT_BITS(inb), .DIGITAL_OUT(dig),
    .OUT_SELECTED(osel), .IN_SELECTED(isel)
  );
  nxb_host host_u (.clk(clk), .bus_w(bus_w), .strobe_n(stb_n), .sel(sel), .hd(hd), .hen(hen));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction : xs
  function automatic logic [11:0] oa();
    return {3'h0, ojp[5], 3'h0, ojp[4], ojp[3:0]};
  endfunction : oa
  function automatic logic [11:0] ia();
    return {3'h0, ijp[6], 2'h1, ijp[5:4], ijp[3:0]};
  endfunction : ia

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic go(input logic [11:0] a, input logic full);
    if (full)
      host_u.addr3(a);
    else
      host_u.cyc(3'h6, {4'h0, a[3:0]}, rd);
    lat = full ? a : {lat[11:4], a[3:0]};
    check({7'h0, osel}, {7'h0, lat == oa()});
    check({7'h0, isel}, {7'h0, lat == ia()});
  endtask : go
  task automatic wr(input logic [2:0] idx, input logic val);
    rs = xs(rs);
    host_u.cyc(3'h7, {rs[7:4], idx, val}, rd);
    if (lat == oa())
      exp_out[idx] = val;
    check(dig, exp_out[7:0]);
  endtask : wr
  task automatic rdc(input logic [2:0] s, input logic [3:0] e, input logic [3:0] m);
    host_u.cyc(s, 8'h00, rd);
    check({4'h0, rd[3:0] & m}, {4'h0, e & m});
  endtask : rdc

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    checks = 0;
    fail_count = 0;
    cyc_n = 0;
    exp_out = 0;
    lat = 12'hFFF;
    rs = xs(32'h52);
    ojp = rs[5:0];
    ijp = rs[12:6];
    inb = rs[19:16];
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(dig, 8'h00);
    check({oe, 2'h0, osel, isel}, 8'h00);
    go(oa(), 1'b1);
    for (int k = 0; k < 16; k++) begin
      rs = xs(rs);
      wr(3'(k), rs[8]);
    end
    for (int s = 0; s < 3; s++)
      rdc(3'(s), 4'h0, 4'h1);
    go({lat[11:4], ~ojp[3:0]}, 1'b0);
    wr(3'h2, ~exp_out[2]);
    rdc(3'h0, 4'h1, 4'h1);
    go(oa(), 1'b0);
    wr(3'h5, 1'b1);
    go(oa() | 12'h200, 1'b1);
    go(oa() | 12'h020, 1'b1);
    go(ia() | 12'h080, 1'b1);
    go(ia() ^ 12'h0C0, 1'b1);
    go(ia(), 1'b1);
    for (int k = 0; k < 4; k++) begin
      rs = xs(rs);
      inb <= rs[3:0];
      rdc(3'h0, rs[3:0], 4'hF);
      rdc(3'h1, 4'h0, 4'h1);
    end
    go(oa(), 1'b1);
    rs = xs(rs);
    host_u.addr16({rs[3:0], oa()});
    lat = oa();
    check({7'h0, osel}, 8'h01);
    check(dig, exp_out[7:0]);
    host_u.bus_reset();
    lat = 12'hFFF;
    exp_out = 0;
    check(dig, 8'h00);
    check({6'h0, osel, isel}, 8'h00);
    give_verdict();
  end
endmodule : nxb_device_bench
